// ### hdl/cdr_ctrl_regs.v
/*
  Five decoder control registers behind an AXI4-Lite slave, with decoded
  mode outputs and shadow bank steering. Assumes one clock, synchronous
  active-low reset, and a master that holds valid and payload until taken.
*/
// Implementation choice: the AXI4-Lite slave port.
// Notes on behaviour
// - Speed register: state code and speed select
// - Pin register: off-track source, kill, pin three
// - Pin register top bit: soft or hard mute
// - Pin function low bits: motor (all four bits zero), subcode, pin four
// - Pin function high bits: de-emphasis, pin five
// - Bank field two/three: to bank two/three
// - Each register takes its fixed reset value
`include "cdr_defs.vh"

module cdr_ctrl_regs (
  input  wire        clk_sys_i,
  input  wire        rst_b_i,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        versatile_pin_one_i,
  input  wire        offtrack_int_i,
  input  wire        motor_line_a_i,
  input  wire        motor_line_b_i,
  input  wire        subcode_qw_i,
  input  wire        deemph_i,
  output reg  [2:0]  op_state_o,
  output reg         stop_standby_o,
  output reg         pause_standby_o,
  output reg         double_speed_o,
  output reg         offtrack_o,
  output reg         mono_kill_o,
  output reg         versatile_pin_three_o,
  output reg         hard_mute_o,
  output wire        versatile_pin_four_o,
  output wire        versatile_pin_five_o,
  output wire        deemph_filter_en_o,
  output reg         brake_6pct_o,
  output reg         lock_to_disc_o,
  output reg         audio_feat_o,
  output reg         quad_speed_o,
  output reg         subcode_on_o,
  output reg         subcode_3wire_o,
  output reg  [1:0]  shadow_bank_select_o,
  output reg         bank_wr_o,
  output reg  [3:0]  bank_addr_o,
  output reg  [3:0]  bank_data_o
);

  reg [3:0] speed_and_standby_control_r;
  reg [3:0] pin_kill_mute_control_r;
  reg [3:0] versatile_pin_function_r;
  reg [3:0] motor_and_feature_control_r;
  reg [3:0] subcode_and_bank_select_r;

  reg       aw_held_r;
  reg [7:0] aw_addr_r;
  reg       w_held_r;
  reg [3:0] w_data_r;
  reg       w_lane0_r;

  // Pin one synchroniser: three stages, change taken when 2 and 3 agree
  reg [2:0] pin_one_sync_r;
  reg       pin_one_clean_r;

  assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_r && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  wire       aw_take = s_axi_awvalid && s_axi_awready;
  wire       w_take  = s_axi_wvalid && s_axi_wready;
  wire       aw_have = aw_held_r || aw_take;
  wire       w_have  = w_held_r || w_take;
  wire [7:0] wr_addr = aw_held_r ? aw_addr_r : s_axi_awaddr;
  wire [3:0] wr_data = w_held_r ? w_data_r : s_axi_wdata[3:0];
  wire       wr_lane = w_held_r ? w_lane0_r : s_axi_wstrb[0];
  wire       wr_go   = aw_have && w_have;
  wire       main_dec = (subcode_and_bank_select_r[1:0] == `CDR_BANK_MAIN);
  wire       in_win  = (wr_addr[7:6] == 2'h0) && (wr_addr[1:0] == 2'h0);
  wire [3:0] win_idx = wr_addr[5:2];
  wire       wr_ok   = in_win && (!main_dec || win_idx >= `CDR_IDX_SPEED);

  always @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      speed_and_standby_control_r <= `CDR_RST_SPEED;
      pin_kill_mute_control_r     <= `CDR_RST_PIN;
      versatile_pin_function_r    <= `CDR_RST_VPIN;
      motor_and_feature_control_r <= `CDR_RST_MOTOR;
      subcode_and_bank_select_r   <= `CDR_RST_SUBC;
      aw_held_r    <= 1'b0;
      aw_addr_r    <= 8'h00;
      w_held_r     <= 1'b0;
      w_data_r     <= 4'h0;
      w_lane0_r    <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `CDR_RESP_OKAY;
      bank_wr_o    <= 1'b0;
      bank_addr_o  <= 4'h0;
      bank_data_o  <= 4'h0;
    end else begin
      bank_wr_o <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_go && !s_axi_bvalid) begin
        aw_held_r    <= 1'b0;
        w_held_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `CDR_RESP_OKAY : `CDR_RESP_SLVERR;
        if (wr_ok && wr_lane) begin
          if (main_dec) begin
            case (win_idx)
              `CDR_IDX_SPEED: speed_and_standby_control_r <= wr_data;
              `CDR_IDX_PIN:   pin_kill_mute_control_r     <= wr_data;
              `CDR_IDX_VPIN:  versatile_pin_function_r    <= wr_data;
              `CDR_IDX_MOTOR: motor_and_feature_control_r <= wr_data;
              `CDR_IDX_SUBC:  subcode_and_bank_select_r   <= wr_data;
              default:        subcode_and_bank_select_r   <= subcode_and_bank_select_r;
            endcase
          end else begin
            // Bank selected: every window address, 0x00 to 0x3C, goes to the shadow bank
            bank_wr_o   <= 1'b1;
            bank_addr_o <= win_idx;
            bank_data_o <= wr_data;
          end
        end
      end else begin
        if (aw_take) begin
          aw_held_r <= 1'b1;
          aw_addr_r <= s_axi_awaddr;
        end
        if (w_take) begin
          w_held_r  <= 1'b1;
          w_data_r  <= s_axi_wdata[3:0];
          w_lane0_r <= s_axi_wstrb[0];
        end
      end
    end
  end

  // Readback of main registers plus filtered pin one level
  wire       rd_in_win = (s_axi_araddr[7:6] == 2'h0) && (s_axi_araddr[1:0] == 2'h0);
  wire [3:0] rd_idx    = s_axi_araddr[5:2];
  reg  [3:0] rd_val;
  reg        rd_hit;

  always @* begin
    rd_hit = 1'b1;
    case (rd_idx)
      `CDR_IDX_SPEED: rd_val = speed_and_standby_control_r;
      `CDR_IDX_PIN:   rd_val = pin_kill_mute_control_r;
      `CDR_IDX_VPIN:  rd_val = versatile_pin_function_r;
      `CDR_IDX_MOTOR: rd_val = motor_and_feature_control_r;
      `CDR_IDX_SUBC:  rd_val = subcode_and_bank_select_r;
      default: begin
        rd_val = 4'h0;
        rd_hit = 1'b0;
      end
    endcase
  end

  always @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `CDR_RESP_OKAY;
      pin_one_sync_r  <= 3'h0;
      pin_one_clean_r <= 1'b0;
    end else begin
      pin_one_sync_r <= {pin_one_sync_r[1:0], versatile_pin_one_i};
      if (pin_one_sync_r[1] == pin_one_sync_r[2]) begin
        pin_one_clean_r <= pin_one_sync_r[2];
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end else if (s_axi_arvalid && !s_axi_rvalid) begin
        s_axi_rvalid <= 1'b1;
        if (s_axi_araddr == `CDR_OFF_BANKWIN) begin
          // Status word: pin one level readable when internal off-track used
          s_axi_rdata <= {31'h0000_0000, pin_one_clean_r & ~pin_kill_mute_control_r[0]};
          s_axi_rresp <= `CDR_RESP_OKAY;
        end else if (rd_in_win && rd_hit) begin
          s_axi_rdata <= {28'h000_0000, rd_val};
          s_axi_rresp <= `CDR_RESP_OKAY;
        end else begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `CDR_RESP_SLVERR;
        end
      end
    end
  end

  // Decoded mode outputs, registered
  always @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      op_state_o            <= `CDR_ST_STOP;
      stop_standby_o        <= 1'b1;
      pause_standby_o       <= 1'b0;
      double_speed_o        <= 1'b0;
      offtrack_o            <= 1'b0;
      mono_kill_o           <= 1'b1;
      versatile_pin_three_o <= 1'b0;
      hard_mute_o           <= 1'b0;
      brake_6pct_o          <= 1'b0;
      lock_to_disc_o        <= 1'b0;
      audio_feat_o          <= 1'b1;
      quad_speed_o          <= 1'b0;
      subcode_on_o          <= 1'b0;
      subcode_3wire_o       <= 1'b0;
      shadow_bank_select_o  <= `CDR_BANK_MAIN;
    end else begin
      op_state_o      <= speed_and_standby_control_r[2:0];
      stop_standby_o  <= speed_and_standby_control_r[2:0] == `CDR_ST_STOP;
      pause_standby_o <= speed_and_standby_control_r[2:0] == `CDR_ST_PAUSE;
      double_speed_o  <= speed_and_standby_control_r[3:2] == `CDR_SPD_DOUBLE;
      offtrack_o      <= pin_kill_mute_control_r[0] ? pin_one_clean_r : offtrack_int_i;
      mono_kill_o     <= pin_kill_mute_control_r[1];
      versatile_pin_three_o <= pin_kill_mute_control_r[2];
      hard_mute_o     <= pin_kill_mute_control_r[3];
      brake_6pct_o    <= motor_and_feature_control_r[0];
      lock_to_disc_o  <= motor_and_feature_control_r[1];
      audio_feat_o    <= motor_and_feature_control_r[2];
      quad_speed_o    <= motor_and_feature_control_r[3];
      subcode_on_o    <= subcode_and_bank_select_r[2];
      subcode_3wire_o <= subcode_and_bank_select_r[3];
      shadow_bank_select_o <= subcode_and_bank_select_r[1:0];
    end
  end

  cdr_pin_mux u_pin_mux (
    .clk_sys_i            (clk_sys_i),
    .rst_b_i              (rst_b_i),
    .vpin_reg_i           (versatile_pin_function_r),
    .motor_line_a_i       (motor_line_a_i),
    .motor_line_b_i       (motor_line_b_i),
    .subcode_qw_i         (subcode_qw_i),
    .deemph_i             (deemph_i),
    .versatile_pin_four_o (versatile_pin_four_o),
    .versatile_pin_five_o (versatile_pin_five_o),
    .deemph_filter_en_o   (deemph_filter_en_o)
  );

endmodule

// ### hdl/cdr_defs.vh
/*
  Constants for the decoder control register block: offsets, fields,
  reset values and codes. Included by the design files by bare name.
*/
`ifndef CDR_DEFS_VH
`define CDR_DEFS_VH

`define CDR_OFF_SPEED      8'h2C
`define CDR_OFF_PIN        8'h30
`define CDR_OFF_VPIN       8'h34
`define CDR_OFF_MOTOR      8'h38
`define CDR_OFF_SUBC       8'h3C
`define CDR_OFF_BANKWIN    8'h40
`define CDR_IDX_SPEED      4'hB
`define CDR_IDX_PIN        4'hC
`define CDR_IDX_VPIN       4'hD
`define CDR_IDX_MOTOR      4'hE
`define CDR_IDX_SUBC       4'hF

`define CDR_RST_SPEED      4'h0
`define CDR_RST_PIN        4'h2
`define CDR_RST_VPIN       4'hF
`define CDR_RST_MOTOR      4'h4
`define CDR_RST_SUBC       4'h0

`define CDR_ST_STOP        3'h0
`define CDR_ST_PAUSE       3'h2
`define CDR_ST_RUN         3'h3
`define CDR_SPD_SINGLE     2'h0
`define CDR_SPD_DOUBLE     2'h2

`define CDR_VP_MOTOR       2'h0
`define CDR_VP_SIGNAL      2'h1
`define CDR_VP_LOW         2'h2
`define CDR_VP_HIGH        2'h3

`define CDR_BANK_MAIN      2'h0

`define CDR_RESP_OKAY      2'h0
`define CDR_RESP_SLVERR    2'h2

`endif

// ### hdl/cdr_pin_mux.v
/*
  Versatile pin four/five function select from the pin function register.
  Assumes the signal sources run on the same clock as the register block.
*/
`include "cdr_defs.vh"

module cdr_pin_mux (
  input  wire       clk_sys_i,
  input  wire       rst_b_i,
  input  wire [3:0] vpin_reg_i,
  input  wire       motor_line_a_i,
  input  wire       motor_line_b_i,
  input  wire       subcode_qw_i,
  input  wire       deemph_i,
  output reg        versatile_pin_four_o,
  output reg        versatile_pin_five_o,
  output reg        deemph_filter_en_o
);

  wire [1:0] sel4 = vpin_reg_i[1:0];
  wire [1:0] sel5 = vpin_reg_i[3:2];
  wire       motor4 = (vpin_reg_i == 4'h0);

  always @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      versatile_pin_four_o <= 1'b1;
      versatile_pin_five_o <= 1'b1;
      deemph_filter_en_o   <= 1'b1;
    end else begin
      if (motor4) begin
        versatile_pin_four_o <= motor_line_a_i;
        versatile_pin_five_o <= motor_line_b_i;
      end else begin
        case (sel4)
          `CDR_VP_SIGNAL: versatile_pin_four_o <= subcode_qw_i;
          `CDR_VP_LOW:    versatile_pin_four_o <= 1'b0;
          `CDR_VP_HIGH:   versatile_pin_four_o <= 1'b1;
          default:        versatile_pin_four_o <= 1'b0;
        endcase
        case (sel5)
          `CDR_VP_SIGNAL: versatile_pin_five_o <= deemph_i;
          `CDR_VP_LOW:    versatile_pin_five_o <= 1'b0;
          `CDR_VP_HIGH:   versatile_pin_five_o <= 1'b1;
          default:        versatile_pin_five_o <= 1'b0;
        endcase
      end
      deemph_filter_en_o <= ~(!motor4 && sel5 == `CDR_VP_SIGNAL);
    end
  end

endmodule

// ### bench/cdr_ctrl_regs_assertions.sv
/*
  Checker for the decoder control register block.
  Assumes binding into cdr_ctrl_regs and one clock domain.
*/
module cdr_ctrl_regs_assertions (
  input logic        clk_sys_i, rst_b_i, s_axi_awvalid, s_axi_awready,
  input logic        s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_arvalid,
  input logic        s_axi_arready, s_axi_rvalid, stop_standby_o, pause_standby_o,
  input logic        mono_kill_o, audio_feat_o, quad_speed_o, subcode_on_o, bank_wr_o,
  input logic [7:0]  s_axi_awaddr, s_axi_araddr,
  input logic [3:0]  s_axi_wstrb,
  input logic [1:0]  s_axi_bresp, s_axi_rresp, shadow_bank_select_o,
  input logic [2:0]  op_state_o,
  input logic [31:0] s_axi_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  wire wt = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_wstrb[0];
  a_stop_code: assert property (stop_standby_o == (op_state_o == 3'h0))
    else $error("stop flag wrong");
  a_pause_code: assert property (pause_standby_o == (op_state_o == 3'h2))
    else $error("pause flag wrong");
  a_main_slverr: assert property (wt && shadow_bank_select_o == 2'h0 &&
    (s_axi_awaddr < 8'h2C || s_axi_awaddr > 8'h3C) |=> s_axi_bvalid && s_axi_bresp == 2'h2)
    else $error("unmapped write accepted");
  a_read_slverr: assert property (s_axi_arvalid && s_axi_arready &&
    (s_axi_araddr < 8'h2C || s_axi_araddr > 8'h40)
    |=> s_axi_rvalid && s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read accepted");
  a_bank_route: assert property (bank_wr_o |-> shadow_bank_select_o != 2'h0)
    else $error("bank write in main mode");
  a_bank_okay: assert property (wt && shadow_bank_select_o != 2'h0 &&
    s_axi_awaddr <= 8'h3C && s_axi_awaddr[1:0] == 2'h0 |=> s_axi_bvalid && s_axi_bresp == 2'h0)
    else $error("bank write refused");
  a_reset_dflt: assert property ($rose(rst_b_i) |-> stop_standby_o && mono_kill_o &&
    audio_feat_o && shadow_bank_select_o == 2'h0 && !subcode_on_o)
    else $error("reset defaults wrong");
  a_mode_stable: assert property (($changed(quad_speed_o) || $changed(subcode_on_o))
    |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
    else $error("mode changed without write");
endmodule

// ### bench/cdr_ctrl_regs_test.sv
/*
  Self-checking bench for the decoder control register block.
  Assumes the design header is on the include path.
*/
`include "cdr_defs.vh"
module cdr_ctrl_regs_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys_i = 1'h0, rst_b_i = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
  logic s_axi_bready = 1'h1, s_axi_arvalid = 1'h0, s_axi_rready = 1'h1;
  logic versatile_pin_one_i = 1'h0, offtrack_int_i = 1'h0, motor_line_a_i = 1'h0;
  logic motor_line_b_i = 1'h1, subcode_qw_i = 1'h1, deemph_i = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h1;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire stop_standby_o, pause_standby_o, double_speed_o, offtrack_o, mono_kill_o;
  wire versatile_pin_three_o, hard_mute_o, versatile_pin_four_o, versatile_pin_five_o;
  wire deemph_filter_en_o, brake_6pct_o, lock_to_disc_o, audio_feat_o, quad_speed_o;
  wire subcode_on_o, subcode_3wire_o, bank_wr_o;
  wire [1:0] s_axi_bresp, s_axi_rresp, shadow_bank_select_o;
  wire [31:0] s_axi_rdata;
  wire [2:0] op_state_o;
  wire [3:0] bank_addr_o, bank_data_o;
  int n_errors = 0, total_checks = 0, n_pulse = 0;
  logic [3:0] pa, pd;
  logic [31:0] d;
  logic [1:0] r;
  cdr_ctrl_regs i_dut (
    .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .versatile_pin_one_i(versatile_pin_one_i),
    .offtrack_int_i(offtrack_int_i), .motor_line_a_i(motor_line_a_i),
    .motor_line_b_i(motor_line_b_i), .subcode_qw_i(subcode_qw_i),
    .deemph_i(deemph_i), .op_state_o(op_state_o),
    .stop_standby_o(stop_standby_o), .pause_standby_o(pause_standby_o),
    .double_speed_o(double_speed_o), .offtrack_o(offtrack_o),
    .mono_kill_o(mono_kill_o), .versatile_pin_three_o(versatile_pin_three_o),
    .hard_mute_o(hard_mute_o), .versatile_pin_four_o(versatile_pin_four_o),
    .versatile_pin_five_o(versatile_pin_five_o), .deemph_filter_en_o(deemph_filter_en_o),
    .brake_6pct_o(brake_6pct_o), .lock_to_disc_o(lock_to_disc_o),
    .audio_feat_o(audio_feat_o), .quad_speed_o(quad_speed_o),
    .subcode_on_o(subcode_on_o), .subcode_3wire_o(subcode_3wire_o),
    .shadow_bank_select_o(shadow_bank_select_o), .bank_wr_o(bank_wr_o),
    .bank_addr_o(bank_addr_o), .bank_data_o(bank_data_o)
  );
  initial forever #2 clk_sys_i = ~clk_sys_i;
  always @(negedge clk_sys_i) begin
    if (bank_wr_o === 1'h1) begin
      n_pulse <= n_pulse + 1;
      pa <= bank_addr_o;
      pd <= bank_data_o;
    end
  end
  task end_sim;
    if (n_errors == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] s, e);
    total_checks++;
    if (s !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task lim(input int i);
    if (i >= 50) begin
      n_errors++;
      end_sim;
    end
  endtask
  task wr(input logic [7:0] a, input logic [3:0] v);
    int i;
    logic ta, tw, tb;
    @(posedge clk_sys_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= {28'h0, v};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    for (i = 0; i < 50; i++) begin
      @(negedge clk_sys_i);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tb = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge clk_sys_i);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
      if (tb) break;
    end
    lim(i);
    @(negedge clk_sys_i);
  endtask
  task rd(input logic [7:0] a);
    int i;
    logic ta, tb;
    @(posedge clk_sys_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    for (i = 0; i < 50; i++) begin
      @(negedge clk_sys_i);
      ta = s_axi_arvalid & s_axi_arready;
      tb = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clk_sys_i);
      if (ta) s_axi_arvalid <= 1'h0;
      if (tb) break;
    end
    lim(i);
  endtask
  task t_reset;
    logic [3:0] rv [5];
    rv = '{`CDR_RST_SPEED, `CDR_RST_PIN, `CDR_RST_VPIN, `CDR_RST_MOTOR, `CDR_RST_SUBC};
    chk("dflt", {stop_standby_o, mono_kill_o, audio_feat_o, versatile_pin_four_o,
      versatile_pin_five_o, shadow_bank_select_o}, 7'h7C);
    for (int k = 0; k < 5; k++) begin
      rd({2'h0, 4'hB + k[3:0], 2'h0});
      chk("rst val", d, {28'h0, rv[k]});
    end
  endtask
  task t_speed;
    logic [3:0] tv [4];
    tv = '{4'h0, 4'h2, 4'h3, 4'hB};
    for (int k = 3; k >= 0; k--) begin
      wr(`CDR_OFF_SPEED, tv[k]);
      chk("state", op_state_o, tv[k][2:0]);
      chk("stop", stop_standby_o, tv[k][2:0] == 3'h0);
      chk("pause", pause_standby_o, tv[k][2:0] == 3'h2);
      chk("double", double_speed_o, tv[k][3:2] == 2'h2);
    end
  endtask
  task t_pin;
    wr(`CDR_OFF_PIN, 4'h1);
    @(posedge clk_sys_i);
    versatile_pin_one_i <= 1'h1;
    repeat (6) @(negedge clk_sys_i);
    chk("ext track", offtrack_o, 1'h1);
    chk("pin c lo", {mono_kill_o, versatile_pin_three_o, hard_mute_o}, 3'h0);
    @(posedge clk_sys_i);
    offtrack_int_i <= 1'h1;
    wr(`CDR_OFF_PIN, 4'hC);
    chk("pin c", {mono_kill_o, versatile_pin_three_o, hard_mute_o}, 3'h3);
    chk("int track hi", offtrack_o, 1'h1);
    rd(`CDR_OFF_BANKWIN);
    chk("status", d[0], 1'h1);
    offtrack_int_i <= 1'h0;
    repeat (3) @(negedge clk_sys_i);
    chk("int track", offtrack_o, 1'h0);
  endtask
  task t_vpin;
    logic [3:0] tv [5];
    tv = '{4'h5, 4'hA, 4'hF, 4'h9, 4'h6};
    wr(`CDR_OFF_VPIN, 4'h0);
    chk("motor", {versatile_pin_four_o, versatile_pin_five_o}, 2'h1);
    for (int k = 0; k < 5; k++) begin
      wr(`CDR_OFF_VPIN, tv[k]);
      chk("v4", versatile_pin_four_o, tv[k][1:0] == 2'h1 || tv[k][1:0] == 2'h3);
      chk("v5", versatile_pin_five_o, tv[k][3:2] == 2'h3);
      chk("filt", deemph_filter_en_o, tv[k][3:2] != 2'h1);
    end
    wr(`CDR_OFF_VPIN, 4'h5);
    @(posedge clk_sys_i);
    subcode_qw_i <= 1'h0;
    deemph_i <= 1'h1;
    repeat (2) @(negedge clk_sys_i);
    chk("v4 sig", versatile_pin_four_o, 1'h0);
    chk("v5 sig", versatile_pin_five_o, 1'h1);
  endtask
  task t_misc;
    wr(`CDR_OFF_MOTOR, 4'hB);
    chk("motor", {quad_speed_o, audio_feat_o, lock_to_disc_o, brake_6pct_o}, 4'hB);
    wr(`CDR_OFF_SUBC, 4'hC);
    chk("subc", {subcode_3wire_o, subcode_on_o, shadow_bank_select_o}, 4'hC);
    wr(8'h28, 4'h1);
    chk("wr err", r, `CDR_RESP_SLVERR);
    rd(8'h44);
    chk("rd err data", d, 32'h0);
    chk("rd err resp", r, `CDR_RESP_SLVERR);
  endtask
  task t_bank;
    int p;
    for (int k = 1; k < 4; k++) begin
      @(posedge clk_sys_i);
      rst_b_i <= 1'h0;
      repeat (3) @(posedge clk_sys_i);
      rst_b_i <= 1'h1;
      wr(`CDR_OFF_SUBC, k[3:0]);
      chk("sel", shadow_bank_select_o, k[1:0]);
      p = n_pulse;
      wr(`CDR_OFF_SPEED, 4'h3);
      chk("bank resp", r, `CDR_RESP_OKAY);
      rd(`CDR_OFF_SPEED);
      chk("main kept", d, 32'h0);
      chk("pulses", n_pulse - p, 32'h1);
      chk("bank at", {pa, pd}, {`CDR_IDX_SPEED, 4'h3});
    end
  endtask
  initial begin
    repeat (3) @(posedge clk_sys_i);
    rst_b_i <= 1'h1;
    @(negedge clk_sys_i);
    t_reset;
    t_speed;
    t_pin;
    t_vpin;
    t_misc;
    t_bank;
    end_sim;
  end
endmodule
bind cdr_ctrl_regs cdr_ctrl_regs_assertions i_chk (
  .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .stop_standby_o(stop_standby_o), .pause_standby_o(pause_standby_o),
  .mono_kill_o(mono_kill_o), .audio_feat_o(audio_feat_o),
  .quad_speed_o(quad_speed_o), .subcode_on_o(subcode_on_o),
  .bank_wr_o(bank_wr_o), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_araddr(s_axi_araddr), .s_axi_wstrb(s_axi_wstrb),
  .s_axi_bresp(s_axi_bresp), .s_axi_rresp(s_axi_rresp),
  .shadow_bank_select_o(shadow_bank_select_o), .op_state_o(op_state_o),
  .s_axi_rdata(s_axi_rdata)
);
